// ### pkg/nbp_pkg.sv
package nbp_pkg;
  localparam int DATA_W      = 16;
  localparam int ADDR_HI     = 31;
  localparam int ADDR_LO     = 2;
  localparam int ADDR_W      = 30;
  localparam int INVAL_LO    = 4;
  localparam int INVAL_W     = 28;
  localparam int BE_W        = 4;
  localparam int PAR_W       = 2;
  localparam logic [3:0] BE_IDLE = 4'hf;
  localparam logic [1:0] PAR_RST = 2'h3;

  typedef enum logic [1:0] {
    NBP_RUN,
    NBP_STOP_GRANT,
    NBP_STOP_CLOCK
  } nbp_pwr_e;

  typedef enum logic [1:0] {
    NBP_IDLE,
    NBP_ADDR,
    NBP_DATA
  } nbp_cyc_e;

  // Even parity: the parity bit makes the ones count of byte plus bit even
  function automatic logic [1:0] even_par(input logic [15:0] d);
    even_par = {^d[15:8], ^d[7:0]};
  endfunction : even_par
endpackage : nbp_pkg

// ### pkg/nbp_keep_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nbp_keep_if;
  logic [15:0] pin_in;
  logic [15:0] drv_en;
  logic [15:0] drv_val;
  logic        keep_on;
  logic [15:0] kept;
  modport keeper (input pin_in, drv_en, drv_val, keep_on, output kept);
  modport user   (output pin_in, drv_en, drv_val, keep_on, input kept);
endinterface : nbp_keep_if
`default_nettype wire

// ### core/nbp_keeper.sv
`timescale 1ns/1ps
`default_nettype none
module nbp_keeper (
  // Clocking
  input  wire logic    clk,
  input  wire logic    rst_b,
  input  wire logic    ce,
  // Pin side
  nbp_keep_if.keeper   kif
);
  logic [15:0] next_kept;

  // Track whoever drives the pin last; our own drive wins while enabled
  always_comb begin
    next_kept = kif.kept;
    for (int i = 0; i < 16; i++) begin
      if (kif.drv_en[i]) begin
        next_kept[i] = kif.drv_val[i];
      end else if (kif.keep_on) begin
        next_kept[i] = kif.pin_in[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kif.kept <= 16'hffff;
    end else if (ce) begin
      kif.kept <= next_kept;
    end
  end
endmodule : nbp_keeper
`default_nettype wire

// ### core/nbp_bus_pins.sv
// Summary of operation
// - Drive byte enables low; float on hold
// - Enable n covers 32-bit data byte n
// - Low byte D7-0; write data from clock two
// - Per-byte parity driven with write data
// - Even parity checked; error only flagged
// - A31-A4 accept invalidation address from system
// - Float address lines during bus/address hold
// - Stop states hold outputs; strobes high
// - Keep last level applied by outsider
// - Wide operands move as 16-bit transfers
// - Everything on rising clock edge
// - Data keepers only in stop states
// - Hold in stop-grant acknowledged, data floated
`timescale 1ns/1ps
`default_nettype none
module nbp_bus_pins (
  // Clocking
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Core request: one 32-bit operand per request
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [29:0] req_addr,
  input  wire logic [3:0]  req_be,
  input  wire logic [31:0] req_wdata,
  input  wire logic        req_fill_first,
  output logic             req_busy,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  // Arbitration and power
  input  wire logic        hold_req,
  input  wire logic        addr_hold,
  input  wire logic        clock_halt_request,
  input  wire logic        clock_stopped,
  output logic             bus_yield_ack,
  output logic             stop_grant_active,
  // Cycle end from system
  input  wire logic        ready_b,
  // Address pins
  input  wire logic [29:0] address_lines_in,
  output logic [29:0]      address_lines_out,
  output logic             address_lines_oe,
  input  wire logic        inval_strobe,
  output logic             inval_valid,
  output logic [27:0]      inval_addr,
  // Control pins
  output logic [3:0]       byte_lane_enables_b,
  output logic             byte_lane_enables_oe,
  output logic             address_strobe_b,
  output logic             pseudo_locked_cycle_b,
  output logic             burst_final_b,
  // Data and parity pins
  input  wire logic [15:0] data_lines_in,
  output logic [15:0]      data_lines_out,
  output logic [15:0]      data_lines_oe,
  input  wire logic        high_byte_parity_in,
  input  wire logic        low_byte_parity_in,
  output logic             high_byte_parity_out,
  output logic             low_byte_parity_out,
  output logic             high_byte_parity_oe,
  output logic             low_byte_parity_oe,
  output logic             parity_error_flag_b
);
  nbp_pkg::nbp_pwr_e pwr, next_pwr;
  nbp_pkg::nbp_cyc_e cyc, next_cyc;
  logic              half, next_half;
  logic              wr, next_wr;
  logic [29:0]       addr, next_addr;
  logic [3:0]        be, next_be;
  logic [31:0]       wdat, next_wdat;
  logic              fill1, next_fill1;
  logic [15:0]       rlow, next_rlow;
  logic              next_rdv, next_ack;
  logic [31:0]       next_rdata;
  logic [29:0]       next_aout;
  logic              next_aoe, next_beoe, next_ads, next_burst_final;
  logic [3:0]        next_bepin;
  logic [15:0]       next_dout, next_doe;
  logic [1:0]        next_pout;
  logic              next_poe, next_perr;
  logic              next_ival;
  logic [27:0]       next_iaddr;
  logic [1:0]        ppin;
  logic              hold_now;

  nbp_keep_if kif ();

  assign hold_now  = hold_req && bus_yield_ack;

  // Data keepers only in stop states, and off while hold is acknowledged
  assign kif.pin_in  = data_lines_in;
  assign kif.drv_en  = data_lines_oe;
  assign kif.drv_val = data_lines_out;
  assign kif.keep_on = (pwr != nbp_pkg::NBP_RUN) && !hold_now;

  nbp_keeper u_keep (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .kif   (kif)
  );

  assign ppin = {high_byte_parity_in, low_byte_parity_in};

  always_comb begin
    next_pwr   = pwr;
    next_cyc   = cyc;
    next_half  = half;
    next_wr    = wr;
    next_addr  = addr;
    next_be    = be;
    next_wdat  = wdat;
    next_fill1 = fill1;
    next_rlow  = rlow;
    next_rdv   = 1'b0;
    next_rdata = rd_data;
    next_ack   = hold_req && (cyc == nbp_pkg::NBP_IDLE);
    next_aout  = address_lines_out;
    next_aoe   = 1'b0;
    next_beoe  = 1'b0;
    next_bepin = byte_lane_enables_b;
    next_ads   = 1'b1;
    next_burst_final = burst_final_b;
    next_dout  = data_lines_out;
    next_doe   = 16'h0000;
    next_pout  = {high_byte_parity_out, low_byte_parity_out};
    next_poe   = 1'b0;
    next_perr  = parity_error_flag_b;
    next_ival  = 1'b0;
    next_iaddr = inval_addr;
    // Power state; stop-clock left only through stop-grant
    case (pwr)
      nbp_pkg::NBP_RUN: begin
        if (clock_halt_request && cyc == nbp_pkg::NBP_IDLE) next_pwr = nbp_pkg::NBP_STOP_GRANT;
      end
      nbp_pkg::NBP_STOP_GRANT: begin
        if (clock_stopped) next_pwr = nbp_pkg::NBP_STOP_CLOCK;
        else if (!clock_halt_request) next_pwr = nbp_pkg::NBP_RUN;
      end
      default: begin
        if (!clock_stopped) next_pwr = nbp_pkg::NBP_STOP_GRANT;
      end
    endcase
    // Snoop while someone else owns the bus
    if (hold_now && inval_strobe) begin
      next_ival  = 1'b1;
      next_iaddr = address_lines_in[29:2];
    end
    // Bus cycle; each operand split into two 16-bit halves
    case (cyc)
      nbp_pkg::NBP_IDLE: begin
        // A take in the edge that enters stop-grant would run with no strobe
        if (req && !hold_req && next_pwr == nbp_pkg::NBP_RUN) begin
          next_cyc   = nbp_pkg::NBP_ADDR;
          next_wr    = req_write;
          next_addr  = req_addr;
          next_be    = req_be;
          next_wdat  = req_wdata;
          next_fill1 = req_fill_first;
          next_half  = 1'b0;
        end
      end
      nbp_pkg::NBP_ADDR: begin
        next_ads   = 1'b0;
        next_cyc   = nbp_pkg::NBP_DATA;
        next_burst_final = 1'b1;
      end
      default: begin
        // Write data and parity from the second clock onward
        // Load the half that must stand when ready is next sampled
        if (wr) begin
          next_dout = (half ^ !ready_b) ? wdat[31:16] : wdat[15:0];
          next_doe  = 16'hffff;
          next_pout = nbp_pkg::even_par(next_dout);
          next_poe  = 1'b1;
        end
        next_burst_final = !(half ^ !ready_b);
        if (!ready_b) begin
          if (!wr) begin
            // Check only; never stops the core
            next_perr = (nbp_pkg::even_par(data_lines_in) == ppin);
            if (half) begin
              next_rdata = {data_lines_in, rlow};
              next_rdv   = 1'b1;
            end else begin
              next_rlow = data_lines_in;
            end
          end
          if (half) begin
            next_cyc   = nbp_pkg::NBP_IDLE;
            next_burst_final = 1'b1;
            next_doe   = 16'h0000;
            next_poe   = 1'b0;
          end
          next_half = !half;
        end
      end
    endcase
    // Pin drive while we own the bus
    if (cyc != nbp_pkg::NBP_IDLE || next_cyc != nbp_pkg::NBP_IDLE) begin
      next_aout  = {next_addr[29:1], next_half};
      next_bepin = ~next_be;
    end
    next_aoe  = !(hold_req || addr_hold);
    next_beoe = !hold_req;
    if (hold_req) begin
      next_doe = 16'h0000;
      next_poe = 1'b0;
    end
    // Stop states: strobes inactive, others keep level
    if (pwr != nbp_pkg::NBP_RUN) begin
      next_ads = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr                   <= nbp_pkg::NBP_RUN;
      cyc                   <= nbp_pkg::NBP_IDLE;
      half                  <= 1'b0;
      wr                    <= 1'b0;
      addr                  <= '0;
      be                    <= '0;
      wdat                  <= '0;
      fill1                 <= 1'b0;
      rlow                  <= '0;
      req_busy              <= 1'b0;
      rd_valid              <= 1'b0;
      rd_data               <= '0;
      bus_yield_ack         <= 1'b0;
      stop_grant_active     <= 1'b0;
      address_lines_out     <= '0;
      address_lines_oe      <= 1'b0;
      inval_valid           <= 1'b0;
      inval_addr            <= '0;
      byte_lane_enables_b   <= nbp_pkg::BE_IDLE;
      byte_lane_enables_oe  <= 1'b0;
      address_strobe_b      <= 1'b1;
      pseudo_locked_cycle_b <= 1'b1;
      burst_final_b         <= 1'b1;
      data_lines_out        <= '0;
      data_lines_oe         <= '0;
      high_byte_parity_out  <= nbp_pkg::PAR_RST[1];
      low_byte_parity_out   <= nbp_pkg::PAR_RST[0];
      high_byte_parity_oe   <= 1'b0;
      low_byte_parity_oe    <= 1'b0;
      parity_error_flag_b   <= 1'b1;
    end else if (ce) begin
      pwr                   <= next_pwr;
      cyc                   <= next_cyc;
      half                  <= next_half;
      wr                    <= next_wr;
      addr                  <= next_addr;
      be                    <= next_be;
      wdat                  <= next_wdat;
      fill1                 <= next_fill1;
      rlow                  <= next_rlow;
      req_busy              <= next_cyc != nbp_pkg::NBP_IDLE;
      rd_valid              <= next_rdv;
      rd_data               <= next_rdata;
      bus_yield_ack         <= next_ack;
      stop_grant_active     <= next_pwr != nbp_pkg::NBP_RUN;
      address_lines_out     <= next_aout;
      address_lines_oe      <= next_aoe;
      inval_valid           <= next_ival;
      inval_addr            <= next_iaddr;
      byte_lane_enables_b   <= next_bepin;
      byte_lane_enables_oe  <= next_beoe;
      address_strobe_b      <= next_ads;
      pseudo_locked_cycle_b <= 1'b1;
      burst_final_b         <= next_burst_final;
      data_lines_out        <= next_dout;
      data_lines_oe         <= next_doe;
      high_byte_parity_out  <= next_pout[1];
      low_byte_parity_out   <= next_pout[0];
      high_byte_parity_oe   <= next_poe;
      low_byte_parity_oe    <= next_poe;
      parity_error_flag_b   <= next_perr;
    end
  end
endmodule : nbp_bus_pins
`default_nettype wire

// ### verification/nbp_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module nbp_sys_model (
  // Clocking
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Pins seen from the system side
  input  wire logic        address_strobe_b,
  input  wire logic [15:0] data_lines_out,
  input  wire logic [15:0] data_lines_oe,
  output logic             ready_b,
  output logic [15:0]      sys_d,
  output logic             sys_hp,
  output logic             sys_lp,
  // Bench control and capture
  input  wire logic [1:0]  waits,
  input  wire logic        bad_par,
  input  wire logic [31:0] rword,
  output logic [31:0]      wword
);
  logic [1:0]  phase;
  logic [1:0]  cnt;
  logic [15:0] last;
  logic [15:0] half;
  logic        rd;
  assign half = phase[1] ? rword[31:16] : rword[15:0];
  assign rd = phase != 2'h0 && data_lines_oe == 16'h0;
  // Released bus shows the inverse of its last level, never a stale copy
  assign sys_d = rd ? half : ~last;
  assign sys_hp = rd ? (^half[15:8]) ^ bad_par : 1'b1;
  assign sys_lp = rd ? (^half[7:0]) ^ bad_par : 1'b1;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      cnt <= 2'h0;
      ready_b <= 1'b1;
      last <= 16'h0;
      wword <= 32'h0;
    end else begin
      last <= sys_d;
      if (!address_strobe_b) begin
        phase <= 2'h1;
        cnt <= waits;
        ready_b <= waits != 2'h0;
      end else if (phase != 2'h0 && !ready_b) begin
        if (&data_lines_oe) wword[{phase[1], 4'h0} +: 16] <= data_lines_out;
        phase <= phase[0] ? 2'h2 : 2'h0;
        cnt <= waits;
        ready_b <= !(phase[0] && waits == 2'h0);
      end else if (phase != 2'h0) begin
        cnt <= cnt - 2'h1;
        ready_b <= cnt != 2'h1;
      end
    end
  end
endmodule : nbp_sys_model
`default_nettype wire

// ### verification/nbp_bus_pins_sva.sv
`timescale 1ns/1ps
`default_nettype none
module nbp_bus_pins_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        ready_b,
  input wire logic        hold_req,
  input wire logic        inval_strobe,
  input wire logic [29:0] address_lines_in,
  input wire logic        req_busy,
  input wire logic        bus_yield_ack,
  input wire logic        stop_grant_active,
  input wire logic [29:0] address_lines_out,
  input wire logic        address_lines_oe,
  input wire logic        inval_valid,
  input wire logic [27:0] inval_addr,
  input wire logic        byte_lane_enables_oe,
  input wire logic        address_strobe_b,
  input wire logic        pseudo_locked_cycle_b,
  input wire logic        burst_final_b,
  input wire logic [15:0] data_lines_out,
  input wire logic [15:0] data_lines_oe,
  input wire logic        high_byte_parity_out,
  input wire logic        low_byte_parity_out,
  input wire logic        high_byte_parity_oe,
  input wire logic        low_byte_parity_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_be_hold; bus_yield_ack |-> !byte_lane_enables_oe; endproperty
  a_be_hold: assert property (p_be_hold) else $error("enables driven in hold");
  property p_addr_hold; bus_yield_ack |-> !address_lines_oe; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address driven in hold");
  property p_par; &data_lines_oe |-> high_byte_parity_oe && low_byte_parity_oe &&
    {high_byte_parity_out, low_byte_parity_out} == {^data_lines_out[15:8], ^data_lines_out[7:0]}; endproperty
  a_par: assert property (p_par) else $error("write parity bad");
  property p_halves; !address_strobe_b |=> burst_final_b && !address_lines_out[0]; endproperty
  a_halves: assert property (p_halves) else $error("first half wrong");
  property p_last; $fell(burst_final_b) |-> address_lines_out[0]; endproperty
  a_last: assert property (p_last) else $error("second half wrong");
  property p_end; req_busy && !ready_b && !burst_final_b |=> !req_busy; endproperty
  a_end: assert property (p_end) else $error("cycle not ended");
  property p_stop; stop_grant_active |-> address_strobe_b && pseudo_locked_cycle_b; endproperty
  a_stop: assert property (p_stop) else $error("strobe active in stop");
  property p_ack; ce && !req_busy |=> bus_yield_ack == $past(hold_req); endproperty
  a_ack: assert property (p_ack) else $error("ack not following hold");
  property p_float; bus_yield_ack |-> data_lines_oe == 16'h0 && !high_byte_parity_oe && !low_byte_parity_oe;
  endproperty
  a_float: assert property (p_float) else $error("data driven in hold");
  property p_inval; hold_req && inval_strobe && bus_yield_ack |=>
    inval_valid && inval_addr == $past(address_lines_in[29:2]);
  endproperty
  a_inval: assert property (p_inval) else $error("invalidate address bad");
  c_write: cover property (&data_lines_oe && !burst_final_b && !ready_b);
  c_inval: cover property (inval_valid);
  c_stop_hold: cover property (stop_grant_active && bus_yield_ack);
endmodule : nbp_bus_pins_chk
bind nbp_bus_pins nbp_bus_pins_chk nbp_bus_pins_chk_inst (.clk, .rst_b, .ce, .ready_b, .hold_req, .inval_strobe,
  .address_lines_in, .req_busy, .bus_yield_ack, .stop_grant_active, .address_lines_out, .address_lines_oe,
  .inval_valid, .inval_addr, .byte_lane_enables_oe, .address_strobe_b, .pseudo_locked_cycle_b, .burst_final_b,
  .data_lines_out, .data_lines_oe, .high_byte_parity_out, .low_byte_parity_out, .high_byte_parity_oe,
  .low_byte_parity_oe);
`default_nettype wire

// ### verification/nbp_bus_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nbp_bus_pins_tb;
  logic clk, rst_b, ce, req, req_write, req_fill_first, hold_req, addr_hold, clock_halt_request, clock_stopped;
  logic bad_par, inval_strobe, ready_b, sys_hp, sys_lp, req_busy, rd_valid, bus_yield_ack, stop_grant_active;
  logic address_lines_oe, inval_valid, byte_lane_enables_oe, address_strobe_b, pseudo_locked_cycle_b, burst_final_b;
  logic high_byte_parity_out, low_byte_parity_out, high_byte_parity_oe, low_byte_parity_oe, parity_error_flag_b;
  logic [29:0] req_addr, sys_addr, address_lines_out;
  logic [3:0]  req_be, byte_lane_enables_b, be_keep;
  logic [31:0] req_wdata, rword, wword, rd_data;
  logic [15:0] data_lines_out, data_lines_oe, sys_d;
  logic [1:0]  waits;
  logic [27:0] inval_addr;
  int          err_count, tests_run, cyc;
  // Each pin resolves from whoever has its driver on
  wire [29:0] address_lines_in = address_lines_oe ? address_lines_out : sys_addr;
  wire [15:0] data_lines_in = (data_lines_out & data_lines_oe) | (sys_d & ~data_lines_oe);
  wire high_byte_parity_in = high_byte_parity_oe ? high_byte_parity_out : sys_hp;
  wire low_byte_parity_in = low_byte_parity_oe ? low_byte_parity_out : sys_lp;
  nbp_bus_pins nbp_bus_pins_inst (.clk, .rst_b, .ce, .req, .req_write, .req_addr, .req_be, .req_wdata,
    .req_fill_first, .req_busy, .rd_valid, .rd_data, .hold_req, .addr_hold, .clock_halt_request, .clock_stopped,
    .bus_yield_ack, .stop_grant_active, .ready_b, .address_lines_in, .address_lines_out, .address_lines_oe,
    .inval_strobe, .inval_valid, .inval_addr, .byte_lane_enables_b, .byte_lane_enables_oe, .address_strobe_b,
    .pseudo_locked_cycle_b, .burst_final_b, .data_lines_in, .data_lines_out, .data_lines_oe, .high_byte_parity_in,
    .low_byte_parity_in, .high_byte_parity_out, .low_byte_parity_out, .high_byte_parity_oe, .low_byte_parity_oe,
    .parity_error_flag_b);
  nbp_sys_model nbp_sys_model_inst (.clk, .rst_b, .address_strobe_b, .data_lines_out(data_lines_in),
    .data_lines_oe, .ready_b, .sys_d, .sys_hp, .sys_lp, .waits, .bad_par, .rword, .wword);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Called at a falling edge; req stays up for one clock, then busy must show the take
  task automatic do_op(input logic wr, input logic bp);
    logic [3:0]  be_seen;
    logic [29:0] a_seen;
    {req_addr, req_be} = {30'($urandom), 4'($urandom)};
    {req_wdata, rword} = {$urandom, $urandom};
    {req_write, bad_par, req_fill_first, waits} = {wr, bp, 1'($urandom), 2'($urandom_range(2))};
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk("busy", 32'h1, req_busy);
    for (int n = 0; n < 30 && req_busy === 1'b1; n++) begin
      if (!address_strobe_b) {be_seen, a_seen} = {byte_lane_enables_b, address_lines_out};
      @(negedge clk);
    end
    chk("enables", {28'h0, ~req_be}, {28'h0, be_seen});
    chk("address", {2'h0, req_addr[29:1], 1'b0}, {2'h0, a_seen});
    if (wr) chk("write word", req_wdata, wword);
    else begin
      chk("read valid", 32'h1, {31'h0, rd_valid});
      chk("read word", rword, rd_data);
      chk("parity flag", {31'h0, !bp}, {31'h0, parity_error_flag_b});
    end
  endtask : do_op
  initial begin
    {rst_b, req, req_write, req_fill_first, hold_req, addr_hold, clock_halt_request, clock_stopped} = '0;
    {bad_par, inval_strobe, req_addr, sys_addr, req_be, req_wdata, rword, waits} = '0;
    {ce, err_count, tests_run, cyc} = {1'b1, 96'h0};
    void'($urandom(32'h781d));
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    do_op(1'b1, 1'b0);
    do_op(1'b0, 1'b1);
    for (int i = 0; i < 24; i++) do_op(1'($urandom), 1'($urandom));
    {hold_req, req} = 2'h3;
    repeat (3) @(negedge clk);
    chk("yield ack", 32'h1, {31'h0, bus_yield_ack});
    chk("refused", 32'h0, {31'h0, req_busy});
    chk("floats", 32'h0, {address_lines_oe, byte_lane_enables_oe, data_lines_oe});
    {sys_addr, inval_strobe} = {30'($urandom), 1'b1};
    @(negedge clk);
    inval_strobe = 1'b0;
    chk("inval", {1'b1, sys_addr[29:2]}, {inval_valid, inval_addr});
    {hold_req, req, addr_hold} = 3'h1;
    repeat (2) @(negedge clk);
    chk("addr hold", 32'h0, {31'h0, address_lines_oe});
    // Clock enable low must freeze the hold acknowledge
    {ce, hold_req} = 2'h1;
    repeat (2) @(negedge clk);
    chk("frozen", 32'h0, {31'h0, bus_yield_ack});
    {ce, hold_req} = 2'h2;
    addr_hold = 1'b0;
    do_op(1'b1, 1'b0);
    {be_keep, clock_halt_request} = {byte_lane_enables_b, 1'b1};
    repeat (4) @(negedge clk);
    clock_stopped = 1'b1;
    @(negedge clk);
    chk("stop", {28'h7, be_keep}, {stop_grant_active, address_strobe_b, pseudo_locked_cycle_b, byte_lane_enables_b});
    {clock_stopped, hold_req} = 2'h1;
    repeat (2) @(negedge clk);
    chk("stop hold", 32'h40000, {bus_yield_ack, data_lines_oe, high_byte_parity_oe, low_byte_parity_oe});
    hold_req = 1'b0;
    repeat (2) @(negedge clk);
    chk("restored", {28'h0, be_keep}, {28'h0, byte_lane_enables_b});
    clock_halt_request = 1'b0;
    repeat (3) @(negedge clk);
    do_op(1'b0, 1'b0);
    report_and_stop();
  end
endmodule : nbp_bus_pins_tb
`default_nettype wire
